/* File: rtl/bfr_pkg.sv */
// Shared constants and types for the block-memory FIFO.
package bfr_pkg;

   // ***************************************************************
   // Default geometry
   // ***************************************************************
   localparam int DEF_DATA_W = 9;
   localparam int DEF_ADDR_W = 10;
   localparam int MIN_ADDR_W = 2;
   localparam int MAX_ADDR_W = 16;

   // Data widths that can keep the old word on the output during a write.
   localparam int RBW_W0 = 9;
   localparam int RBW_W1 = 18;
   localparam int RBW_W2 = 36;

   // ***************************************************************
   // Register map
   // ***************************************************************
   localparam int BUS_ADDR_W = 8;
   localparam int BUS_DATA_W = 32;
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_FULL_THR = 8'h04;
   localparam logic [7:0] REG_AFULL_THR = 8'h08;
   localparam logic [7:0] REG_AEMPTY_THR = 8'h0C;
   localparam logic [7:0] REG_STATUS = 8'h10;

   // Status word layout.
   localparam int STAT_EMPTY_BIT = 0;
   localparam int STAT_AEMPTY_BIT = 1;
   localparam int STAT_AFULL_BIT = 2;
   localparam int STAT_FULL_BIT = 3;
   localparam int STAT_CNT_LSB = 16;

   // Control word layout and reset values of the thresholds.
   localparam int CTRL_MODE_LSB = 0;
   localparam int AEMPTY_THR_RST = 1;
   localparam int AFULL_THR_GAP = 1;

   // ***************************************************************
   // Write behaviour of the writing port
   // ***************************************************************
   typedef enum logic [1:0] {
      BFR_WM_NORMAL = 2'h0,
      BFR_WM_THRU = 2'h1,
      BFR_WM_RBW = 2'h2
   } bfr_wmode_t;

endpackage

/* File: rtl/bfr_mem.sv */
// Dual-port storage array with registered output latches for both ports.
`timescale 1ns/1ps
module bfr_mem #(
   parameter int DATA_W = bfr_pkg::DEF_DATA_W,
   parameter int ADDR_W = bfr_pkg::DEF_ADDR_W
) (
   input wire logic clk,
   input wire logic wr_en,
   input wire logic [ADDR_W-1:0] wr_addr,
   input wire logic [DATA_W-1:0] wr_data,
   input wire bfr_pkg::bfr_wmode_t wr_mode,
   input wire logic rd_en,
   input wire logic [ADDR_W-1:0] rd_addr,
   input wire logic clr_a,
   input wire logic clr_b,
   output logic [DATA_W-1:0] a_q,
   output logic [DATA_W-1:0] b_q
);

   logic [DATA_W-1:0] mem_reg [0:(1<<ADDR_W)-1];

   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem_reg[wr_addr] <= wr_data;
      end
   end

   // The array read sees the old word, so the read-before-write case needs no bypass.
   always_ff @(posedge clk) begin
      if (clr_a) begin
         a_q <= '0;
      end else if (wr_en) begin
         case (wr_mode)
            bfr_pkg::BFR_WM_THRU: begin
               a_q <= wr_data;
            end
            bfr_pkg::BFR_WM_RBW: begin
               a_q <= mem_reg[wr_addr];
            end
            default: begin
               a_q <= a_q;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (clr_b) begin
         b_q <= '0;
      end else if (rd_en) begin
         b_q <= mem_reg[rd_addr];
      end
   end

endmodule

/* File: rtl/bfr_fifo.sv */
// Block-memory FIFO with flag thresholds, retransmit clear and output latch resets.
`timescale 1ns/1ps
module bfr_fifo #(
   parameter int DATA_W = bfr_pkg::DEF_DATA_W,
   parameter int ADDR_W = bfr_pkg::DEF_ADDR_W
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [31:0] reg_rdata,
   input wire logic write_side_clock,
   input wire logic push_clock_gate,
   input wire logic push_enable,
   input wire logic [DATA_W-1:0] push_data,
   input wire logic read_side_clock,
   input wire logic pop_clock_gate,
   input wire logic pop_enable,
   output logic [DATA_W-1:0] pop_data,
   output logic [DATA_W-1:0] port_a_data,
   output logic full_flag,
   output logic almost_full_flag,
   output logic almost_empty_flag,
   output logic empty_flag,
   input wire logic port_a_reset,
   input wire logic port_b_reset,
   input wire logic global_reset_n
);

   // ***************************************************************
   // Elaboration checks
   // ***************************************************************
   if (ADDR_W < bfr_pkg::MIN_ADDR_W || ADDR_W > bfr_pkg::MAX_ADDR_W) begin : g_bad_addr_w
      $error("bfr_fifo: ADDR_W out of the supported range");
   end
   if (DATA_W < 1) begin : g_bad_data_w
      $error("bfr_fifo: DATA_W must be at least one");
   end

   localparam bit RBW_OK = (DATA_W == bfr_pkg::RBW_W0) || (DATA_W == bfr_pkg::RBW_W1)
      || (DATA_W == bfr_pkg::RBW_W2);
   localparam logic [ADDR_W-1:0] FULL_MAX = '1;
   localparam logic [ADDR_W-1:0] THR_MIN = ADDR_W'(1);
   localparam logic [ADDR_W-1:0] AF_RST = FULL_MAX - ADDR_W'(bfr_pkg::AFULL_THR_GAP);
   localparam logic [ADDR_W-1:0] AE_RST = ADDR_W'(bfr_pkg::AEMPTY_THR_RST);

   // ***************************************************************
   // Declarations
   // ***************************************************************
   logic ws_clk_d_reg;
   logic rs_clk_d_reg;
   logic ws_rise;
   logic rs_rise;
   logic [ADDR_W-1:0] wr_ptr_reg;
   logic [ADDR_W-1:0] wr_ptr_next;
   logic [ADDR_W-1:0] rd_ptr_reg;
   logic [ADDR_W-1:0] rd_ptr_next;
   logic [ADDR_W-1:0] cnt;
   logic [ADDR_W-1:0] cnt_next;
   logic push_fire;
   logic pop_fire;
   logic clr_a;
   logic clr_b;
   bfr_pkg::bfr_wmode_t mode_reg;
   logic [ADDR_W-1:0] full_thr_reg;
   logic [ADDR_W-1:0] af_thr_reg;
   logic [ADDR_W-1:0] ae_thr_reg;
   logic [ADDR_W-1:0] wr_val;
   logic wr_val_fits;
   logic [31:0] status_word;

   // ***************************************************************
   // Memory clock edges
   // ***************************************************************
   // The two memory clocks arrive as ordinary inputs, synchronous to sys_clk,
   // so a rising edge is seen as one sys_clk cycle of high after low.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ws_clk_d_reg <= 1'b0;
         rs_clk_d_reg <= 1'b0;
      end else begin
         ws_clk_d_reg <= write_side_clock;
         rs_clk_d_reg <= read_side_clock;
      end
   end

   assign ws_rise = write_side_clock & ~ws_clk_d_reg;
   assign rs_rise = read_side_clock & ~rs_clk_d_reg;

   // ***************************************************************
   // Pointers
   // ***************************************************************
   assign cnt = wr_ptr_reg - rd_ptr_reg;

   // A push needs its edge, its gate and its enable; the port A clear wins over both, the port B clear over the pop only.
   assign push_fire = ws_rise & push_clock_gate & push_enable
      & (cnt < full_thr_reg) & ~port_a_reset;
   assign pop_fire = rs_rise & pop_clock_gate & pop_enable
      & (cnt != '0) & ~port_a_reset & ~port_b_reset;

   // The clears do not wait for a memory clock edge and ignore the enables.
   always_comb begin
      wr_ptr_next = wr_ptr_reg;
      rd_ptr_next = rd_ptr_reg;
      if (port_a_reset) begin
         wr_ptr_next = '0;
         rd_ptr_next = '0;
      end else begin
         if (push_fire) begin
            wr_ptr_next = wr_ptr_reg + THR_MIN;
         end
         if (port_b_reset) begin
            rd_ptr_next = '0;
         end else if (pop_fire) begin
            rd_ptr_next = rd_ptr_reg + THR_MIN;
         end
      end
   end

   assign cnt_next = wr_ptr_next - rd_ptr_next;

   // Retransmit restarts at address zero, so it only replays correctly while the
   // write pointer has not wrapped since the last full clear.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         wr_ptr_reg <= '0;
      end else begin
         wr_ptr_reg <= wr_ptr_next;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rd_ptr_reg <= '0;
      end else begin
         rd_ptr_reg <= rd_ptr_next;
      end
   end

   // ***************************************************************
   // Flags
   // ***************************************************************
   always_ff @(posedge sys_clk) begin
      if (rst || port_a_reset) begin
         full_flag <= 1'b0;
         almost_full_flag <= 1'b0;
      end else if (ws_rise) begin
         full_flag <= (cnt_next >= full_thr_reg);
         almost_full_flag <= (cnt_next >= af_thr_reg);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst || port_a_reset) begin
         empty_flag <= 1'b1;
         almost_empty_flag <= 1'b1;
      end else if (rs_rise) begin
         empty_flag <= (cnt_next == '0);
         almost_empty_flag <= (cnt_next <= ae_thr_reg);
      end
   end

   // ***************************************************************
   // Control registers
   // ***************************************************************
   assign wr_val = reg_wdata[ADDR_W-1:0];
   assign wr_val_fits = (reg_wdata[31:ADDR_W] == '0);

   // Read-before-write is only kept where the width supports it; else normal.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         mode_reg <= bfr_pkg::BFR_WM_NORMAL;
      end else if (reg_write && reg_addr == bfr_pkg::REG_CTRL) begin
         case (reg_wdata[bfr_pkg::CTRL_MODE_LSB +: 2])
            2'h1: begin
               mode_reg <= bfr_pkg::BFR_WM_THRU;
            end
            2'h2: begin
               mode_reg <= RBW_OK ? bfr_pkg::BFR_WM_RBW : bfr_pkg::BFR_WM_NORMAL;
            end
            default: begin
               mode_reg <= bfr_pkg::BFR_WM_NORMAL;
            end
         endcase
      end
   end

   // An out-of-range threshold write is dropped so the flag ordering stays sane.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         full_thr_reg <= FULL_MAX;
      end else if (reg_write && reg_addr == bfr_pkg::REG_FULL_THR && wr_val_fits
            && wr_val >= THR_MIN && wr_val > af_thr_reg && wr_val > ae_thr_reg) begin
         full_thr_reg <= wr_val;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         af_thr_reg <= AF_RST;
      end else if (reg_write && reg_addr == bfr_pkg::REG_AFULL_THR && wr_val_fits
            && wr_val >= THR_MIN && wr_val < full_thr_reg) begin
         af_thr_reg <= wr_val;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ae_thr_reg <= AE_RST;
      end else if (reg_write && reg_addr == bfr_pkg::REG_AEMPTY_THR && wr_val_fits
            && wr_val >= THR_MIN && wr_val < full_thr_reg) begin
         ae_thr_reg <= wr_val;
      end
   end

   always_comb begin
      status_word = '0;
      status_word[bfr_pkg::STAT_EMPTY_BIT] = empty_flag;
      status_word[bfr_pkg::STAT_AEMPTY_BIT] = almost_empty_flag;
      status_word[bfr_pkg::STAT_AFULL_BIT] = almost_full_flag;
      status_word[bfr_pkg::STAT_FULL_BIT] = full_flag;
      status_word[bfr_pkg::STAT_CNT_LSB +: ADDR_W] = cnt;
   end

   // Read data stands only in the cycle after the strobe; unmapped reads give zero.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         reg_rdata <= '0;
      end else if (reg_read) begin
         case (reg_addr)
            bfr_pkg::REG_CTRL: begin
               reg_rdata <= 32'(mode_reg);
            end
            bfr_pkg::REG_FULL_THR: begin
               reg_rdata <= 32'(full_thr_reg);
            end
            bfr_pkg::REG_AFULL_THR: begin
               reg_rdata <= 32'(af_thr_reg);
            end
            bfr_pkg::REG_AEMPTY_THR: begin
               reg_rdata <= 32'(ae_thr_reg);
            end
            bfr_pkg::REG_STATUS: begin
               reg_rdata <= status_word;
            end
            default: begin
               reg_rdata <= '0;
            end
         endcase
      end else begin
         reg_rdata <= '0;
      end
   end

   // ***************************************************************
   // Storage and output latches
   // ***************************************************************
   assign clr_a = rst | port_a_reset | ~global_reset_n;
   assign clr_b = rst | port_b_reset | ~global_reset_n;

   bfr_mem #(
      .DATA_W(DATA_W),
      .ADDR_W(ADDR_W)
   ) u_mem (
      .clk(sys_clk),
      .wr_en(push_fire),
      .wr_addr(wr_ptr_reg),
      .wr_data(push_data),
      .wr_mode(mode_reg),
      .rd_en(pop_fire),
      .rd_addr(rd_ptr_reg),
      .clr_a(clr_a),
      .clr_b(clr_b),
      .a_q(port_a_data),
      .b_q(pop_data)
   );

   // ***************************************************************
   // Assertions
   // ***************************************************************
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   AST_PUSH_REFUSED: assert property (
      (ws_rise && push_clock_gate && push_enable && cnt >= full_thr_reg && !port_a_reset)
      |=> (wr_ptr_reg == $past(wr_ptr_reg)))
      else $error("push accepted while full");

   AST_POP_REFUSED: assert property (
      (rs_rise && pop_clock_gate && pop_enable && cnt == '0 && !port_a_reset && !port_b_reset)
      |=> $stable(rd_ptr_reg) && $stable(pop_data))
      else $error("pop accepted while empty");

   AST_CLEAR_A: assert property (
      port_a_reset |=> (wr_ptr_reg == '0 && rd_ptr_reg == '0 && empty_flag
         && almost_empty_flag && !full_flag && !almost_full_flag && port_a_data == '0))
      else $error("port A reset did not clear the FIFO");

   AST_CLEAR_B: assert property (
      (port_b_reset && !port_a_reset && !push_fire) |=> (rd_ptr_reg == '0
         && wr_ptr_reg == $past(wr_ptr_reg) && pop_data == '0))
      else $error("port B reset disturbed the write side");

   AST_GLOBAL: assert property (
      !global_reset_n |=> (pop_data == '0 && port_a_data == '0))
      else $error("global reset left an output latch set");

   AST_FULL_DOMAIN: assert property (
      (!ws_rise && !port_a_reset && !rst) |=> $stable(full_flag) && $stable(almost_full_flag))
      else $error("full side flag moved without a write clock edge");

   AST_EMPTY_DOMAIN: assert property (
      (!rs_rise && !port_a_reset && !rst) |=> $stable(empty_flag) && $stable(almost_empty_flag))
      else $error("empty side flag moved without a read clock edge");

   AST_AFULL_LEVEL: assert property (
      (ws_rise && !port_a_reset) |=> (almost_full_flag == (cnt >= $past(af_thr_reg))))
      else $error("almost full disagrees with occupancy");

   AST_THRU: assert property (
      (push_fire && mode_reg == bfr_pkg::BFR_WM_THRU && global_reset_n)
      |=> (port_a_data == $past(push_data)))
      else $error("write-through word missing on port A");

   AST_NORMAL: assert property (
      (push_fire && mode_reg == bfr_pkg::BFR_WM_NORMAL && global_reset_n)
      |=> $stable(port_a_data))
      else $error("normal mode changed port A during a write");

   COV_FILL: cover property (push_fire ##1 full_flag);
   COV_DRAIN: cover property (pop_fire ##1 empty_flag);
   COV_RETRANSMIT: cover property ((cnt != '0) ##1 port_b_reset ##[1:8] pop_fire);
   COV_RBW: cover property (push_fire && mode_reg == bfr_pkg::BFR_WM_RBW);

endmodule

/* File: testbench/bfr_user.sv */
// Core-side model that drives the push and pop ports of the block-memory FIFO.
`timescale 1ns/1ps
module bfr_user #(
   parameter int DATA_W = 9
) (
   input wire logic sys_clk,
   output logic write_side_clock,
   output logic push_clock_gate,
   output logic push_enable,
   output logic [DATA_W-1:0] push_data,
   output logic read_side_clock,
   output logic pop_clock_gate,
   output logic pop_enable
);
   initial begin
      write_side_clock = 1'b0;
      push_clock_gate = 1'b0;
      push_enable = 1'b0;
      push_data = '0;
      read_side_clock = 1'b0;
      pop_clock_gate = 1'b0;
      pop_enable = 1'b0;
   end

   // ***************************************************************
   // Transfers
   // ***************************************************************
   // Memory clocks stand still between transfers, and the enables drop with them.
   // A released data bus shows the inverse word so that a stale value never matches.
   task automatic push(input logic [DATA_W-1:0] d, input logic en, input int idle);
      @(posedge sys_clk);
      write_side_clock <= 1'b1;
      push_clock_gate <= 1'b1;
      push_enable <= en;
      push_data <= d;
      @(posedge sys_clk);
      write_side_clock <= 1'b0;
      push_clock_gate <= 1'b0;
      push_enable <= 1'b0;
      push_data <= ~d;
      repeat (idle + 1) @(posedge sys_clk);
   endtask

   task automatic pop(input logic en, input int idle);
      @(posedge sys_clk);
      read_side_clock <= 1'b1;
      pop_clock_gate <= 1'b1;
      pop_enable <= en;
      @(posedge sys_clk);
      read_side_clock <= 1'b0;
      pop_clock_gate <= 1'b0;
      pop_enable <= 1'b0;
      repeat (idle + 1) @(posedge sys_clk);
   endtask
endmodule

/* File: testbench/test_bfr_fifo.sv */
// Self-checking testbench for the block-memory FIFO.
`timescale 1ns/1ps
module test_bfr_fifo;
   localparam int DW = 9;
   localparam int AW = 3;
   typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] e;} bfr_row_t;
   logic sys_clk, rst, reg_write, reg_read, port_a_reset, port_b_reset, global_reset_n;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, rd;
   logic wck, wg, we, rck, rg, re, ff, af, ae, ef;
   logic [DW-1:0] wd, pop_data, port_a_data;
   int error_cnt = 0;
   int compares = 0;
   bfr_row_t rows [9] = '{'{8'h04, 32'h8, 32'h7}, '{8'h04, 32'h0, 32'h7},
      '{8'h08, 32'h7, 32'h6}, '{8'h0C, 32'h0, 32'h1}, '{8'h0C, 32'h7, 32'h1},
      '{8'h00, 32'h3, 32'h0}, '{8'h00, 32'h1, 32'h1}, '{8'h00, 32'h2, 32'h2},
      '{8'h20, 32'h5, 32'h0}};

   bfr_fifo #(.DATA_W(DW), .ADDR_W(AW)) bfr_fifo_inst (.sys_clk(sys_clk), .rst(rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .write_side_clock(wck), .push_clock_gate(wg), .push_enable(we),
      .push_data(wd), .read_side_clock(rck), .pop_clock_gate(rg), .pop_enable(re),
      .pop_data(pop_data), .port_a_data(port_a_data), .full_flag(ff), .almost_full_flag(af),
      .almost_empty_flag(ae), .empty_flag(ef), .port_a_reset(port_a_reset),
      .port_b_reset(port_b_reset), .global_reset_n(global_reset_n));

   bfr_user #(.DATA_W(DW)) bfr_user_inst (.sys_clk(sys_clk), .write_side_clock(wck),
      .push_clock_gate(wg), .push_enable(we), .push_data(wd), .read_side_clock(rck),
      .pop_clock_gate(rg), .pop_enable(re));

   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   // ***************************************************************
   // Helpers
   // ***************************************************************
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Flag nibble order is full, almost full, almost empty, empty.
   task automatic flags(input logic [3:0] e);
      chk({28'h0, ff, af, ae, ef}, {28'h0, e});
   endtask

   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge sys_clk);
      reg_write <= 1'b0;
   endtask

   task automatic reg_rd(input logic [7:0] a);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge sys_clk);
      reg_read <= 1'b0;
      #1 rd = reg_rdata;
   endtask

   task automatic occ(input logic [31:0] e);
      reg_rd(bfr_pkg::REG_STATUS);
      chk((rd >> bfr_pkg::STAT_CNT_LSB) & 32'h7, e);
   endtask

   // Enables are already low here, so the clears meet the sequencing the memory needs.
   task automatic clr(input logic [2:0] m);
      @(posedge sys_clk);
      port_a_reset <= m[0];
      port_b_reset <= m[1];
      global_reset_n <= ~m[2];
      @(posedge sys_clk);
      port_a_reset <= 1'b0;
      port_b_reset <= 1'b0;
      global_reset_n <= 1'b1;
      #1;
   endtask

   task automatic finish_test();
      $display("compares=%0d error_cnt=%0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge sys_clk);
      error_cnt++;
      finish_test();
   end

   // ***************************************************************
   // Tests
   // ***************************************************************
   initial begin
      rst = 1'b1;
      reg_write = 1'b0;
      reg_read = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      port_a_reset = 1'b0;
      port_b_reset = 1'b0;
      global_reset_n = 1'b1;
      repeat (5) @(posedge sys_clk);
      rst <= 1'b0;
      #1 flags(4'h3);
      chk({23'h0, pop_data}, 32'h0);
      foreach (rows[i]) begin
         reg_wr(rows[i].a, rows[i].w);
         reg_rd(rows[i].a);
         chk(rd, rows[i].e);
      end
      $display("register table done");
      reg_wr(bfr_pkg::REG_CTRL, 32'h0);
      bfr_user_inst.push(9'h0A5, 1'b1, 0);
      #1 chk({23'h0, port_a_data}, 32'h0);
      flags(4'h3);
      bfr_user_inst.pop(1'b1, 2);
      #1 chk({23'h0, pop_data}, 32'h0A5);
      flags(4'h3);
      clr(3'b001);
      flags(4'h3);
      occ(32'h0);
      $display("normal mode done");
      reg_wr(bfr_pkg::REG_CTRL, 32'h1);
      for (int i = 0; i < 8; i++) begin
         bfr_user_inst.push(9'h100 | 9'(i), 1'b1, i % 2);
         #1 if (i < 7) chk({23'h0, port_a_data}, 32'h100 | i);
         flags({i >= 6, i >= 5, 2'b11});
      end
      occ(32'h7);
      $display("fill done");
      bfr_user_inst.pop(1'b1, 0);
      bfr_user_inst.pop(1'b1, 0);
      #1 chk({23'h0, pop_data}, 32'h101);
      flags(4'hC);
      clr(3'b010);
      chk({23'h0, pop_data}, 32'h0);
      occ(32'h7);
      bfr_user_inst.pop(1'b1, 0);
      #1 chk({23'h0, pop_data}, 32'h100);
      clr(3'b100);
      chk({23'h0, pop_data}, 32'h0);
      chk({23'h0, port_a_data}, 32'h0);
      occ(32'h6);
      $display("retransmit done");
      for (int j = 1; j < 8; j++) begin
         bfr_user_inst.pop(1'b1, 0);
         #1 chk({23'h0, pop_data}, 32'h100 | (j < 7 ? j : 6));
         flags({2'b11, j >= 5, j >= 6});
      end
      bfr_user_inst.push(9'h000, 1'b0, 0);
      #1 flags(4'h3);
      $display("drain done");
      clr(3'b001);
      reg_wr(bfr_pkg::REG_CTRL, 32'h2);
      reg_wr(bfr_pkg::REG_AFULL_THR, 32'h2);
      reg_wr(bfr_pkg::REG_AEMPTY_THR, 32'h3);
      bfr_user_inst.push(9'h1FF, 1'b1, 0);
      #1 chk({23'h0, port_a_data}, 32'h100);
      bfr_user_inst.push(9'h1FE, 1'b1, 0);
      #1 chk({23'h0, port_a_data}, 32'h101);
      flags(4'h7);
      bfr_user_inst.pop(1'b0, 0);
      #1 flags(4'h6);
      $display("read-before-write done");
      reg_wr(bfr_pkg::REG_FULL_THR, 32'h4);
      reg_rd(bfr_pkg::REG_FULL_THR);
      chk(rd, 32'h4);
      @(posedge sys_clk);
      #1 chk(reg_rdata, 32'h0);
      for (int k = 0; k < 3; k++) begin
         bfr_user_inst.push(9'h0C3, 1'b1, 0);
         #1 chk({23'h0, port_a_data}, 32'h102 | (k > 0));
         flags({k >= 1, 3'h6});
      end
      occ(32'h4);
      $display("programmed full threshold done");
      @(posedge sys_clk);
      rst <= 1'b1;
      @(posedge sys_clk);
      rst <= 1'b0;
      #1 flags(4'h3);
      chk({23'h0, port_a_data}, 32'h0);
      reg_rd(bfr_pkg::REG_FULL_THR);
      chk(rd, 32'h7);
      occ(32'h0);
      $display("mid-run reset done");
      finish_test();
   end
endmodule
